// ### rtl/cec_ahb_slave.sv
// AHB-Lite slave front end with one wait state
`timescale 1ns/1ns
module cec_ahb_slave (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // AHB-Lite
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Register side
  input  wire logic [31:0] rd_data_i,
  output logic             wr_o,
  output logic [7:0]       addr_o
);
  import cec_pkg::*;

  logic       pend_reg;
  logic       wr_reg;
  logic       ok_reg;
  logic [7:0] addr_reg;
  logic       take;
  logic       ok;

  assign take   = hsel_i && htrans_i[1] && hready_i;
  // Only aligned words in the low 256 bytes are mapped
  assign ok     = (haddr_i[31:8] == 24'h00_0000) && (haddr_i[1:0] == 2'h0) && (hsize_i == HSIZE_WORD);
  assign wr_o   = pend_reg && wr_reg && ok_reg;
  assign addr_o = addr_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_reg    <= 1'b0;
      wr_reg      <= 1'b0;
      ok_reg      <= 1'b0;
      addr_reg    <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      pend_reg <= take;
      if (take) begin
        wr_reg      <= hwrite_i;
        ok_reg      <= ok;
        addr_reg    <= haddr_i[7:0];
        hreadyout_o <= 1'b0;
      end else if (pend_reg) begin
        hreadyout_o <= 1'b1;
        hrdata_o    <= ok_reg ? rd_data_i : 32'h0000_0000;
      end
    end
  end

endmodule // cec_ahb_slave

// ### rtl/cec_counter.sv
// Configurable event counter: step logic, send policies, reset, alarm and lock
`timescale 1ns/1ns
module cec_counter #(
  parameter int unsigned MS_CYCLES = cec_pkg::CYC_PER_MS
) (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Trigger pulses from the input
  input  wire logic        trig_i,
  // Telegrams to the bus
  output cec_pkg::cec_tx_t count_tx_o,
  output cec_pkg::cec_tx_t alarm_tx_o,
  output logic             lock_read_o
);
  import cec_pkg::*;

  typedef enum logic {ST_RUN, ST_LOCK_WAIT} cec_state_t;

  cec_ctrl_t   ctrl_reg;
  cec_state_t  state_reg;
  logic [31:0] start_reg;
  logic [31:0] limit_reg;
  logic [31:0] step_reg;
  logic [31:0] interval_reg;
  logic [31:0] alarm_reg;
  logic [16:0] pulses_reg;
  logic [15:0] cycle_reg;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [31:0] ret_count_reg;
  logic        lock_reg;
  logic [15:0] cyc_ms_reg;
  logic [15:0] lock_ms_reg;
  logic [31:0] rd_data;
  logic [7:0]  bus_addr;
  logic        bus_wr;
  logic        step_ev;
  logic        ms_tick;

  function automatic logic lt(input logic sgn, input logic [31:0] a, input logic [31:0] b);
    lt = sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction

  cec_ahb_slave u_bus (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hready_i    (hready_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .rd_data_i   (rd_data),
    .wr_o        (bus_wr),
    .addr_o      (bus_addr)
  );

  // Write decode
  wire logic [31:0] wd       = hwdata_i;
  wire logic wr_ctrl         = bus_wr && (bus_addr == OFS_CTRL);
  wire logic wr_start        = bus_wr && (bus_addr == OFS_START);
  wire logic wr_limit        = bus_wr && (bus_addr == OFS_LIMIT);
  wire logic wr_step         = bus_wr && (bus_addr == OFS_STEP);
  wire logic wr_pulses       = bus_wr && (bus_addr == OFS_PULSES);
  wire logic wr_interval     = bus_wr && (bus_addr == OFS_INTERVAL);
  wire logic wr_cycle        = bus_wr && (bus_addr == OFS_CYCLE);
  wire logic wr_alarm        = bus_wr && (bus_addr == OFS_ALARM);
  wire logic wr_count        = bus_wr && (bus_addr == OFS_COUNT);
  wire logic wr_event        = bus_wr && (bus_addr == OFS_EVENT);

  wire logic ev_trig         = wr_event && wd[EV_TRIG];
  wire logic ev_rst          = wr_event && wd[EV_RST];
  wire logic ev_lock         = wr_event && wd[EV_LOCK];
  wire logic ev_read         = wr_event && wd[EV_READ];
  wire logic ev_busret       = wr_event && wd[EV_BUSRET];
  wire logic ev_dl           = wr_event && wd[EV_DLDONE];

  // Lock also holds during the wait for a lock read answer
  wire logic waiting         = (state_reg == ST_LOCK_WAIT);
  wire logic locked          = ctrl_reg.lock_en && (lock_reg || waiting);
  wire logic sgn             = ctrl_reg.signed_mode;

  // Pulse prescaler and millisecond base
  cec_pulse_div u_pulses (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pulse_i ((trig_i || ev_trig) && !locked),
    .clear_i (ev_busret || ev_dl || wr_pulses),
    .n_i     (pulses_reg),
    .step_o  (step_ev)
  );

  cec_pulse_div u_ms (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pulse_i (1'b1),
    .clear_i (1'b0),
    .n_i     (17'(MS_CYCLES)),
    .step_o  (ms_tick)
  );

  // Bounds and step arithmetic
  wire logic start_low       = !lt(sgn, limit_reg, start_reg);
  wire logic [31:0] lo       = start_low ? start_reg : limit_reg;
  wire logic [31:0] hi       = start_low ? limit_reg : start_reg;
  wire logic [31:0] sum      = count_reg + step_reg;
  wire logic [31:0] diff     = count_reg - step_reg;
  // Wrap is caught by comparing with the old count
  wire logic up_sat          = lt(sgn, sum, count_reg) || lt(sgn, hi, sum);
  wire logic dn_sat          = lt(sgn, count_reg, diff) || lt(sgn, diff, lo);
  wire logic [31:0] up_val   = up_sat ? hi : sum;
  wire logic [31:0] dn_val   = dn_sat ? lo : diff;
  wire logic [31:0] stepped  = ctrl_reg.dir_up ? up_val : dn_val;
  wire logic [31:0] wr_clamp = lt(sgn, wd, lo) ? lo : (lt(sgn, hi, wd) ? hi : wd);

  // Reset telegram qualification
  wire logic rst_val         = wd[EV_RSTVAL];
  wire logic rst_qual        = (ctrl_reg.rst_mode == RM_EITHER) ||
                               ((ctrl_reg.rst_mode == RM_ON) && rst_val) ||
                               ((ctrl_reg.rst_mode == RM_OFF) && !rst_val);
  wire logic rst_hit         = ctrl_reg.rst_en && ev_rst && rst_qual && !locked;
  wire logic ovw_hit         = ctrl_reg.overwritable && wr_count && !locked;
  wire logic keep_dl         = ctrl_reg.ret_mode && !ctrl_reg.ovw_dl;

  always_comb begin
    count_next = count_reg;
    if (ev_busret) begin
      count_next = ctrl_reg.ret_mode ? ret_count_reg : start_reg;
    end else if (ev_dl) begin
      count_next = keep_dl ? ret_count_reg : start_reg;
    end else if (rst_hit) begin
      count_next = start_reg;
    end else if (ovw_hit) begin
      count_next = wr_clamp;
    end else if (step_ev) begin
      count_next = stepped;
    end
  end

  // Send policy decode
  wire cec_policy_t pol      = ctrl_reg.policy;
  wire logic pol_chg         = (pol == POL_CHANGE) || (pol == POL_CHANGE_CYC);
  wire logic pol_iv          = (pol == POL_INTERVAL) || (pol == POL_INTERVAL_CYC);
  wire logic pol_cyc         = (pol == POL_CYCLIC) || (pol == POL_CHANGE_CYC) || (pol == POL_INTERVAL_CYC);
  wire logic changed         = (count_next != count_reg) && !ev_busret && !ev_dl;
  wire logic [31:0] mag      = (sgn && count_next[31]) ? (32'h0000_0000 - count_next) : count_next;
  // Division is costly but only one divider is needed here
  wire logic on_iv           = (interval_reg != 32'h0000_0000) && ((mag % interval_reg) == 32'h0000_0000);
  wire logic cyc_fire        = ms_tick && (cycle_reg != 16'h0000) && (cyc_ms_reg + 16'h0001 >= cycle_reg);
  wire logic send_ret        = ev_busret && ctrl_reg.send_ret && (pol != POL_UPDATE);
  wire logic send_chg        = changed && pol_chg;
  wire logic send_iv         = changed && pol_iv && on_iv;
  wire logic send_cyc        = cyc_fire && pol_cyc;
  wire logic send_any        = ev_read || send_ret || send_chg || send_iv || send_cyc;

  // Alarm condition
  wire logic [31:0] target   = ctrl_reg.alarm_sel ? alarm_reg : limit_reg;
  wire logic alarm_hit       = ctrl_reg.alarm_en && changed && (count_next == target);

  // Read mux
  wire logic [31:0] status   = {30'h0, waiting, locked};
  assign rd_data = (bus_addr == OFS_CTRL)     ? {15'h0000, ctrl_reg} :
                   (bus_addr == OFS_START)    ? start_reg :
                   (bus_addr == OFS_LIMIT)    ? limit_reg :
                   (bus_addr == OFS_STEP)     ? step_reg :
                   (bus_addr == OFS_PULSES)   ? {15'h0000, pulses_reg} :
                   (bus_addr == OFS_INTERVAL) ? interval_reg :
                   (bus_addr == OFS_CYCLE)    ? {16'h0000, cycle_reg} :
                   (bus_addr == OFS_ALARM)    ? alarm_reg :
                   (bus_addr == OFS_COUNT)    ? count_reg :
                   (bus_addr == OFS_STATUS)   ? status : 32'h0000_0000;

  // Pulse count written out of range is clamped to 1..100000
  wire logic [16:0] pulses_wd = (wd == 32'h0000_0000) ? PULSES_MIN :
                                (wd > {15'h0000, PULSES_MAX}) ? PULSES_MAX : wd[16:0];

  // Configuration registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg     <= cec_ctrl_t'(RST_CTRL);
      start_reg    <= RST_START;
      limit_reg    <= RST_LIMIT;
      step_reg     <= RST_STEP;
      pulses_reg   <= RST_PULSES;
      interval_reg <= RST_INTERVAL;
      cycle_reg    <= RST_CYCLE;
      alarm_reg    <= RST_ALARM;
    end else begin
      if (wr_ctrl) ctrl_reg <= cec_ctrl_t'(wd[16:0]);
      if (wr_start) start_reg <= wd;
      if (wr_limit) limit_reg <= wd;
      if (wr_step) step_reg <= wd;
      if (wr_pulses) pulses_reg <= pulses_wd;
      if (wr_interval) interval_reg <= wd;
      if (wr_cycle) cycle_reg <= wd[15:0];
      if (wr_alarm) alarm_reg <= wd;
    end
  end

  // Count and its retained copy
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg     <= RST_START;
      ret_count_reg <= RST_START;
    end else begin
      count_reg     <= count_next;
      ret_count_reg <= count_next;
    end
  end

  // Cycle timer restarts on bus return
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_ms_reg <= 16'h0000;
    end else if (ev_busret || cyc_fire) begin
      cyc_ms_reg <= 16'h0000;
    end else if (ms_tick) begin
      cyc_ms_reg <= cyc_ms_reg + 16'h0001;
    end
  end

  // Outgoing telegrams
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_tx_o <= '0;
      alarm_tx_o <= '0;
    end else begin
      count_tx_o.valid <= send_any;
      count_tx_o.value <= count_next;
      alarm_tx_o.valid <= alarm_hit;
      alarm_tx_o.value <= ALARM_ON;
    end
  end

  // Lock state and bus-return lock handling
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_RUN;
      lock_reg    <= 1'b0;
      lock_ms_reg <= 16'h0000;
      lock_read_o <= 1'b0;
    end else begin
      lock_read_o <= 1'b0;
      if (ev_busret && ctrl_reg.lock_en) begin
        lock_ms_reg <= 16'h0000;
        case (ctrl_reg.lock_ret)
          LR_UNLOCKED: begin
            lock_reg  <= 1'b0;
            state_reg <= ST_RUN;
          end
          LR_LOCKED: begin
            lock_reg  <= 1'b1;
            state_reg <= ST_RUN;
          end
          LR_READ: begin
            lock_reg    <= 1'b0;
            lock_read_o <= 1'b1;
            state_reg   <= ST_LOCK_WAIT;
          end
          LR_KEEP: begin
            state_reg <= ST_RUN;
          end
          default: begin
            state_reg <= ST_RUN;
          end
        endcase
      end else if (ev_lock && ctrl_reg.lock_en) begin
        lock_reg  <= wd[EV_LOCKVAL];
        state_reg <= ST_RUN;
      end else begin
        case (state_reg)
          ST_LOCK_WAIT: begin
            if (ms_tick) lock_ms_reg <= lock_ms_reg + 16'h0001;
            if (ms_tick && (lock_ms_reg + 16'h0001 >= LOCK_TO_MS)) begin
              state_reg <= ST_RUN;
            end
          end
          default: begin
            state_reg <= ST_RUN;
          end
        endcase
      end
    end
  end

endmodule // cec_counter

// ### rtl/cec_pkg.sv
// Package of constants and types for the configurable event counter
package cec_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_START    = 8'h04;
  localparam logic [7:0] OFS_LIMIT    = 8'h08;
  localparam logic [7:0] OFS_STEP     = 8'h0C;
  localparam logic [7:0] OFS_PULSES   = 8'h10;
  localparam logic [7:0] OFS_INTERVAL = 8'h14;
  localparam logic [7:0] OFS_CYCLE    = 8'h18;
  localparam logic [7:0] OFS_ALARM    = 8'h1C;
  localparam logic [7:0] OFS_COUNT    = 8'h20;
  localparam logic [7:0] OFS_EVENT    = 8'h24;
  localparam logic [7:0] OFS_STATUS   = 8'h28;

  // Event register bit positions (write one to fire, except EV_RSTVAL and EV_LOCKVAL, which carry values)
  localparam int EV_TRIG    = 0;
  localparam int EV_RST     = 1;
  localparam int EV_RSTVAL  = 2;
  localparam int EV_LOCK    = 3;
  localparam int EV_LOCKVAL = 4;
  localparam int EV_READ    = 5;
  localparam int EV_BUSRET  = 6;
  localparam int EV_DLDONE  = 7;

  // Reset values
  localparam logic [31:0] RST_START    = 32'h0000_0000;
  localparam logic [31:0] RST_LIMIT    = 32'h0000_FFFF;
  localparam logic [31:0] RST_STEP     = 32'h0000_0001;
  localparam logic [16:0] RST_PULSES   = 17'h0_0001;
  localparam logic [31:0] RST_INTERVAL = 32'h0000_0001;
  localparam logic [15:0] RST_CYCLE    = 16'h03E8;
  localparam logic [31:0] RST_ALARM    = 32'h0000_0000;

  // Limits
  localparam logic [16:0] PULSES_MIN = 17'h0_0001;
  localparam logic [16:0] PULSES_MAX = 17'h1_86A0;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam logic [31:0] ALARM_ON   = 32'h0000_0001;

  // Timing
  localparam int          CLK_NS     = 20;
  localparam int          MS_NS      = 1000000;
  localparam int          CYC_PER_MS = MS_NS / CLK_NS;
  localparam logic [15:0] LOCK_TO_MS = 16'h03E8;

  typedef enum logic [2:0] {
    POL_UPDATE, POL_CHANGE, POL_INTERVAL, POL_CYCLIC, POL_CHANGE_CYC, POL_INTERVAL_CYC
  } cec_policy_t;

  typedef enum logic [1:0] {RM_OFF, RM_ON, RM_EITHER} cec_rst_mode_t;

  typedef enum logic [1:0] {LR_UNLOCKED, LR_LOCKED, LR_READ, LR_KEEP} cec_lock_ret_t;

  // Control register layout, bit 0 is dir_up
  typedef struct packed {
    logic          signed_mode;
    logic          overwritable;
    cec_lock_ret_t lock_ret;
    logic          lock_en;
    logic          ovw_dl;
    logic          ret_mode;
    logic          alarm_sel;
    logic          alarm_en;
    cec_rst_mode_t rst_mode;
    logic          rst_en;
    logic          send_ret;
    cec_policy_t   policy;
    logic          dir_up;
  } cec_ctrl_t;

  localparam logic [16:0] RST_CTRL = 17'h0_0001;

  typedef struct packed {
    logic        valid;
    logic [31:0] value;
  } cec_tx_t;

endpackage

// ### rtl/cec_pulse_div.sv
// Pulse divider: one step out for every n pulses in
`timescale 1ns/1ns
module cec_pulse_div (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Control
  input  wire logic        pulse_i,
  input  wire logic        clear_i,
  input  wire logic [16:0] n_i,
  // Result
  output logic             step_o
);

  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  logic        hit;

  // A count of zero behaves as one
  assign hit      = pulse_i && (cnt_reg + 17'h0_0001 >= n_i);
  assign step_o   = hit;
  assign cnt_next = hit ? 17'h0_0000 : cnt_reg + 17'h0_0001;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 17'h0_0000;
    end else if (clear_i) begin
      cnt_reg <= 17'h0_0000;
    end else if (pulse_i) begin
      cnt_reg <= cnt_next;
    end
  end

endmodule // cec_pulse_div

// ### verification/cec_bus_peer.sv
// Bus peer model: tallies the telegrams the counter sends
`timescale 1ns/1ns
module cec_bus_peer (
  // System
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Telegrams from the device
  input  wire cec_pkg::cec_tx_t count_tx_i,
  input  wire cec_pkg::cec_tx_t alarm_tx_i,
  input  wire logic             lock_read_i,
  // Tallies
  output logic [31:0]           n_count_o,
  output logic [31:0]           n_alarm_o,
  output logic [31:0]           n_lock_read_o,
  output logic [31:0]           last_count_o
);
  import cec_pkg::*;
  // Pulses last one cycle, so each edge is one telegram
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      n_count_o     <= 32'h0;
      n_alarm_o     <= 32'h0;
      n_lock_read_o <= 32'h0;
      last_count_o  <= 32'h0;
    end else begin
      n_count_o     <= n_count_o + {31'h0, count_tx_i.valid};
      n_alarm_o     <= n_alarm_o + {31'h0, alarm_tx_i.valid};
      n_lock_read_o <= n_lock_read_o + {31'h0, lock_read_i};
      if (count_tx_i.valid) last_count_o <= count_tx_i.value;
    end
  end
endmodule // cec_bus_peer

// ### verification/cec_counter_properties.sv
// Concurrent checks on the event counter ports
`timescale 1ns/1ns
module cec_counter_properties #(
  parameter int unsigned MS_CYCLES = cec_pkg::CYC_PER_MS
) (
  // Watched ports
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  input wire logic             hsel_i,
  input wire logic [1:0]       htrans_i,
  input wire logic             hready_i,
  input wire logic [31:0]      hrdata_o,
  input wire logic             hreadyout_o,
  input wire logic             hresp_o,
  input wire cec_pkg::cec_tx_t alarm_tx_o,
  input wire logic             lock_read_o
);
  import cec_pkg::*;
  wire taken = hsel_i && htrans_i[1] && hready_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_resp_okay; hresp_o == 1'b0; endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("response not OKAY");
  property p_taken_wait; taken |=> !hreadyout_o; endproperty
  a_taken_wait: assert property (p_taken_wait) else $error("no wait state after request");
  property p_wait_one; !hreadyout_o |=> hreadyout_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state longer than one cycle");
  property p_wait_cause; !hreadyout_o |-> $past(taken); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait state without request");
  // Read data must hold between completions
  property p_rdata_hold; hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved while idle");
  property p_alarm_value; alarm_tx_o.valid |-> alarm_tx_o.value == ALARM_ON; endproperty
  a_alarm_value: assert property (p_alarm_value) else $error("alarm telegram value wrong");
  property p_alarm_pulse; alarm_tx_o.valid |=> !alarm_tx_o.valid; endproperty
  a_alarm_pulse: assert property (p_alarm_pulse) else $error("alarm held over one cycle");
  property p_lock_read_pulse; lock_read_o |=> (!lock_read_o) [*2]; endproperty
  a_lock_read_pulse: assert property (p_lock_read_pulse) else $error("lock read repeated");
  property p_lock_read_cause; lock_read_o |-> !$past(hreadyout_o); endproperty
  a_lock_read_cause: assert property (p_lock_read_cause) else $error("lock read not after write");
  c_taken: cover property (taken);
  c_alarm: cover property (alarm_tx_o.valid);
  c_lock_read: cover property (lock_read_o);
endmodule // cec_counter_properties

bind cec_counter cec_counter_properties #(.MS_CYCLES(MS_CYCLES)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .alarm_tx_o(alarm_tx_o),
  .lock_read_o(lock_read_o)
);

// ### verification/configurable_event_counter_tb.sv
// Self-checking bench for the configurable event counter
`timescale 1ns/1ns
module configurable_event_counter_tb;
  import cec_pkg::*;
  localparam int unsigned MS = 10;
  localparam logic [31:0] BUSRET = 32'h40;
  localparam logic [31:0] DLDONE = 32'h80;
  logic        clk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, trig_i, lock_read_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, v, n0, cnt, n_cnt, n_alm, n_lrd, last_cnt;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i;
  cec_tx_t     count_tx_o, alarm_tx_o;
  int          err_count = 0;
  int          checks = 0;

  cec_counter #(.MS_CYCLES(MS)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .trig_i(trig_i),
    .count_tx_o(count_tx_o), .alarm_tx_o(alarm_tx_o), .lock_read_o(lock_read_o)
  );
  cec_bus_peer u_peer (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .count_tx_i(count_tx_o), .alarm_tx_i(alarm_tx_o),
    .lock_read_i(lock_read_o), .n_count_o(n_cnt), .n_alarm_o(n_alm), .n_lock_read_o(n_lrd),
    .last_count_o(last_cnt)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    v = hrdata_o;
  endtask
  // Half a cycle lets the peer tallies settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    @(negedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(v, exp);
  endtask
  task automatic trig(input int n);
    repeat (n) begin
      @(posedge clk_i);
      trig_i <= 1'b1;
      @(posedge clk_i);
      trig_i <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic t_regs();
    rdchk(OFS_CTRL, 32'h1);
    rdchk(OFS_LIMIT, 32'hFFFF);
    rdchk(OFS_STEP, 32'h1);
    rdchk(OFS_START, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk(8'h40, 32'h0);
    wr(OFS_PULSES, 32'h0);
    rdchk(OFS_PULSES, 32'h1);
    wr(OFS_PULSES, 32'h1_86A1);
    rdchk(OFS_PULSES, 32'h1_86A0);
    wr(OFS_LIMIT, 32'h7FFF_FFFF);
    rdchk(OFS_LIMIT, 32'h7FFF_FFFF);
  endtask
  task automatic t_step();
    wr(OFS_LIMIT, 32'h64);
    wr(OFS_STEP, 32'h5);
    wr(OFS_PULSES, 32'h3);
    wr(OFS_CTRL, 32'h3);
    n0 = n_cnt;
    trig(2);
    rdchk(OFS_COUNT, 32'h0);
    trig(1);
    rdchk(OFS_COUNT, 32'h5);
    chk(n_cnt - n0, 32'h1);
    wr(OFS_CTRL, 32'h2);
    trig(6);
    rdchk(OFS_COUNT, 32'h0);
  endtask
  task automatic t_policy();
    wr(OFS_STEP, 32'h1);
    wr(OFS_PULSES, 32'h1);
    wr(OFS_INTERVAL, 32'h2);
    wr(OFS_CYCLE, 32'h0);
    cnt = 32'h0;
    for (int p = 0; p < 6; p++) begin
      wr(OFS_CTRL, 32'h1 | (p << 1));
      repeat (2) begin
        n0 = n_cnt;
        trig(1);
        cnt++;
        chk(n_cnt - n0, {31'h0, p == 1 || p == 4 || ((p == 2 || p == 5) && !cnt[0])});
      end
    end
    wr(OFS_CTRL, 32'h1);
    n0 = n_cnt;
    wr(OFS_EVENT, 32'h20);
    chk(n_cnt - n0, 32'h1);
    chk(last_cnt, cnt);
  endtask
  task automatic t_cyclic();
    wr(OFS_CYCLE, 32'h2);
    wr(OFS_CTRL, 32'h7);
    repeat (5) @(posedge clk_i);
    n0 = n_cnt;
    repeat (4 * MS) @(posedge clk_i);
    chk(n_cnt - n0, 32'h2);
    wr(OFS_CYCLE, 32'h0);
    n0 = n_cnt;
    repeat (4 * MS) @(posedge clk_i);
    chk(n_cnt - n0, 32'h0);
  endtask
  task automatic t_reset();
    wr(OFS_START, 32'hA);
    for (int m = 0; m < 3; m++) begin
      wr(OFS_CTRL, 32'h21 | (m << 6));
      wr(OFS_EVENT, BUSRET);
      trig(1);
      wr(OFS_EVENT, 32'h2);
      rdchk(OFS_COUNT, m == 1 ? 32'hB : 32'hA);
      trig(1);
      wr(OFS_EVENT, 32'h6);
      rdchk(OFS_COUNT, m == 0 ? 32'hB : 32'hA);
    end
  endtask
  task automatic t_alarm();
    wr(OFS_START, 32'h0);
    wr(OFS_LIMIT, 32'h3);
    wr(OFS_ALARM, 32'h2);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CTRL, 32'h101 | (s << 9));
      wr(OFS_EVENT, BUSRET);
      n0 = n_alm;
      trig(1);
      chk(n_alm - n0, 32'h0);
      trig(s == 0 ? 3 : 1);
      chk(n_alm - n0, 32'h1);
    end
  endtask
  task automatic t_retain();
    wr(OFS_START, 32'hA);
    wr(OFS_LIMIT, 32'h64);
    wr(OFS_CTRL, 32'h11);
    n0 = n_cnt;
    wr(OFS_EVENT, BUSRET);
    chk(n_cnt - n0, 32'h0);
    wr(OFS_CTRL, 32'h13);
    wr(OFS_EVENT, BUSRET);
    chk(n_cnt - n0, 32'h1);
    chk(last_cnt, 32'hA);
    trig(2);
    wr(OFS_CTRL, 32'h413);
    wr(OFS_EVENT, BUSRET);
    chk(last_cnt, 32'hC);
    wr(OFS_EVENT, DLDONE);
    rdchk(OFS_COUNT, 32'hC);
    wr(OFS_CTRL, 32'hC13);
    wr(OFS_EVENT, DLDONE);
    rdchk(OFS_COUNT, 32'hA);
  endtask
  task automatic t_ovw();
    wr(OFS_COUNT, 32'h32);
    rdchk(OFS_COUNT, 32'hA);
    wr(OFS_CTRL, 32'h8001);
    wr(OFS_COUNT, 32'h32);
    rdchk(OFS_COUNT, 32'h32);
    wr(OFS_COUNT, 32'h1F4);
    rdchk(OFS_COUNT, 32'h64);
    wr(OFS_COUNT, 32'h3);
    rdchk(OFS_COUNT, 32'hA);
    // Signed bounds: unsigned compare would keep this value unclamped
    wr(OFS_START, 32'hFFFF_FFFB);
    wr(OFS_LIMIT, 32'h5);
    wr(OFS_CTRL, 32'h1_8001);
    wr(OFS_COUNT, 32'hFFFF_FFF0);
    rdchk(OFS_COUNT, 32'hFFFF_FFFB);
    wr(OFS_START, 32'hA);
    wr(OFS_LIMIT, 32'h64);
  endtask
  task automatic t_lock();
    wr(OFS_COUNT, 32'hA);
    wr(OFS_CTRL, 32'h1001);
    wr(OFS_EVENT, 32'h18);
    rdchk(OFS_STATUS, 32'h1);
    trig(2);
    rdchk(OFS_COUNT, 32'hA);
    for (int r = 0; r < 4; r++) begin
      wr(OFS_CTRL, 32'h1001 | (r << 13));
      wr(OFS_EVENT, 32'h18);
      n0 = n_lrd;
      wr(OFS_EVENT, BUSRET);
      chk(n_lrd - n0, {31'h0, r == 2});
      rdchk(OFS_STATUS, r == 0 ? 32'h0 : (r == 2 ? 32'h3 : 32'h1));
    end
    wr(OFS_EVENT, 32'h8);
    rdchk(OFS_STATUS, 32'h0);
    wr(OFS_CTRL, 32'h5001);
    wr(OFS_EVENT, BUSRET);
    wr(OFS_EVENT, 32'h8);
    rdchk(OFS_STATUS, 32'h0);
    wr(OFS_EVENT, BUSRET);
    repeat (1000 * MS) @(posedge clk_i);
    rdchk(OFS_STATUS, 32'h0);
    trig(1);
    rdchk(OFS_COUNT, 32'hB);
    wr(OFS_EVENT, 32'h1);
    rdchk(OFS_COUNT, 32'hC);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Longest wait is the lock answer timeout
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end
  initial begin
    rst_n_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    hwrite_i = 1'b0;
    htrans_i = 2'h0;
    hsize_i = HSIZE_WORD;
    hwdata_i = 32'h0;
    trig_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_step();
    t_policy();
    t_cyclic();
    t_reset();
    t_alarm();
    t_retain();
    t_ovw();
    t_lock();
    wrap_up();
  end
endmodule // configurable_event_counter_tb
